/* File: src/msg_fifo.sv */
// Message queue storage: small flip-flop FIFO of report identifiers.
// Assumes push and pop come from the same clock; push when full is dropped.
`timescale 1ns/100ps
`default_nettype none
module msg_fifo
  import objproto_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       push,
  input  wire logic [7:0] push_id,
  input  wire logic       pop,
  output logic [7:0]      head_id,
  output logic            empty
);
  typedef struct packed {
    logic [MSGQ_DEPTH-1:0][7:0] mem;
    logic [1:0]                 wp;
    logic [1:0]                 rp;
    logic [2:0]                 cnt;
  } fifo_t;
  fifo_t s_q, s_d;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    s_d = s_q;
    if (pop && s_q.cnt != 3'h0) begin
      s_d.rp  = s_q.rp + 2'h1;
      s_d.cnt = s_d.cnt - 3'h1;
    end
    if (push && s_q.cnt != 3'(MSGQ_DEPTH)) begin
      s_d.mem[s_q.wp] = push_id;
      s_d.wp  = s_q.wp + 2'h1;
      s_d.cnt = s_d.cnt + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign head_id = (s_q.cnt == 3'h0) ? RPT_NONE : s_q.mem[s_q.rp];
  assign empty   = (s_q.cnt == 3'h0);
endmodule : msg_fifo
`default_nettype wire

/* File: src/objproto_device.sv */
// Device end: object store, command interpreter, message queue, debug
// port enable, self-test sequencer. Host reaches it over objproto_if.
`timescale 1ns/100ps
`default_nettype none
module objproto_device
  import objproto_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  objproto_if.device      link,
  input  wire logic [2:0] fault_in,       // Power, pin, limit faults
  input  wire logic [7:0] diag_data,      // Raw debug sample
  output logic            debug_active,   // Debug serial port on
  output logic            pins_alt_en,    // Alternate pin function
  output logic            test_gpio,      // Self-test fail on GPIO
  output logic            touch_enabled,
  output logic [7:0]      idle_acquisition_interval,
  output logic [7:0]      active_acquisition_interval
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_NV   = 2'b01,
    ST_TEST = 2'b10
  } dev_state_t;

  typedef struct packed {
    dev_state_t       st;
    logic [3:0]       nv_obj;
    logic [15:0]      timer;
    logic [15:0]      period_cnt;
    logic             boot_test_pend;
    logic             debug_on;
    logic             gpio_fail;
    logic [7:0]       rdata;
    logic [6:0][2:0][7:0] obj_f;   // Objects 7..13 x fields 0..2
  } dev_t;
  dev_t s_q, s_d;

  logic        rst_all;
  logic        push;
  logic [7:0]  push_id;
  logic        pop;
  logic [7:0]  head_id;
  logic        q_empty;
  logic [15:0] period_len;   // Periodic test period in cycles

  function automatic logic [2:0] oidx(input logic [3:0] o);
    oidx = 3'(o - OBJ_POWER);
  endfunction

  assign rst_all = sys_rst || !link.dev_reset_n;

  // Periodic test period: interval field times the tick length
  assign period_len = 16'(s_q.obj_f[oidx(OBJ_TEST)][FLD_ARG1]) *
                      16'(PERIOD_TICK);

  // ********************************************************************
  // Message queue
  // ********************************************************************
  msg_fifo u_q (
    .mclk    (mclk),
    .sys_rst (rst_all),
    .push    (push),
    .push_id (push_id),
    .pop     (pop),
    .head_id (head_id),
    .empty   (q_empty)
  );

  // ********************************************************************
  // Command interpretation, object writes, self-test sequencing
  // ********************************************************************
  always_comb begin
    s_d     = s_q;
    push    = 1'b0;
    push_id = RPT_NONE;
    pop     = 1'b0;
    // Field writes land in the object store; command object is special
    // Field 3 does not exist; a write to it is dropped
    if (link.wr_stb && link.obj >= OBJ_POWER && link.obj <= OBJ_TOUCH &&
        link.fld != 2'h3) begin
      s_d.obj_f[oidx(link.obj)][link.fld] = link.wdata;
    end
    // Reading the queue object pops one message
    if (link.rd_stb) begin
      case (link.obj)
        OBJ_MSG: begin
          s_d.rdata = head_id;
          pop       = 1'b1;
        end
        OBJ_DIAG: s_d.rdata = diag_data;
        OBJ_CMD:  s_d.rdata = {6'h00, s_q.st};
        default: begin
          if (link.obj >= OBJ_POWER && link.obj <= OBJ_TOUCH &&
              link.fld != 2'h3) begin
            s_d.rdata = s_q.obj_f[oidx(link.obj)][link.fld];
          end else begin
            s_d.rdata = 8'h00;
          end
        end
      endcase
    end
    // Periodic test interval counter; zero interval means off. It only
    // runs while idle, so a save or a test in progress stretches the
    // period rather than queueing a test behind it
    if (s_q.obj_f[oidx(OBJ_TEST)][FLD_ARG1] == FIELD_RST) begin
      s_d.period_cnt = 16'h0000;
    end else if (s_q.st == ST_IDLE) begin
      s_d.period_cnt = s_q.period_cnt + 16'h0001;
    end
    // Commands that arrive while a save or a test runs are dropped
    case (s_q.st)
      ST_IDLE: begin
        if (link.wr_stb && link.obj == OBJ_CMD) begin
          case (link.wdata)
            CMD_SAVE_NV: begin
              s_d.st     = ST_NV;
              s_d.nv_obj = link.fld == FLD_CTRL ? OBJ_CMD : link.obj;
              s_d.timer  = 16'(NV_CYC);
            end
            CMD_DEBUG_ON:  s_d.debug_on = 1'b1;
            CMD_DEBUG_OFF: s_d.debug_on = 1'b0;
            CMD_SELFTEST:  s_d.st       = ST_TEST;
            default: ;
          endcase
        end else if (s_q.boot_test_pend) begin
          s_d.boot_test_pend = 1'b0;
          s_d.st             = ST_TEST;
        end else if (s_q.period_cnt != 16'h0000 &&
                     s_q.period_cnt >= period_len) begin
          s_d.period_cnt = 16'h0000;
          s_d.st       = ST_TEST;
        end
      end
      ST_NV: begin
        if (s_q.timer == 16'h0001) begin
          s_d.st = ST_IDLE;
          if (s_q.obj_f[oidx(OBJ_TEST)][FLD_CTRL][CTRL_REPORT_EN]) begin
            push    = 1'b1;
            push_id = RPT_NV_DONE | {4'h0, s_q.nv_obj};
          end
        end else begin
          s_d.timer = s_q.timer - 16'h0001;
        end
      end
      ST_TEST: begin
        s_d.st = ST_IDLE;
        // Selected groups in ARG0 bits 2:0; enable bit gates all of it
        if (s_q.obj_f[oidx(OBJ_TEST)][FLD_CTRL][CTRL_EN]) begin
          s_d.gpio_fail = |(fault_in &
                           s_q.obj_f[oidx(OBJ_TEST)][FLD_ARG0][2:0]);
          if (s_q.obj_f[oidx(OBJ_TEST)][FLD_CTRL][CTRL_REPORT_EN]) begin
            push    = 1'b1;
            push_id = s_d.gpio_fail ? RPT_TEST_BAD : RPT_TEST_OK;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      s_q                <= '0;
      s_q.boot_test_pend <= 1'b1;    // Power-on test runs after reset
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign link.rdata             = s_q.rdata;
  assign link.message_pending_n = q_empty;
  assign debug_active           = s_q.debug_on;
  assign pins_alt_en            = !s_q.debug_on;
  assign test_gpio = s_q.gpio_fail &&
                     s_q.obj_f[oidx(OBJ_GPIO)][FLD_CTRL][CTRL_EN];
  assign touch_enabled = s_q.obj_f[oidx(OBJ_TOUCH)][FLD_CTRL][CTRL_EN];
  assign idle_acquisition_interval   = s_q.obj_f[oidx(OBJ_POWER)][FLD_ARG0];
  assign active_acquisition_interval = s_q.obj_f[oidx(OBJ_POWER)][FLD_ARG1];
endmodule : objproto_device
`default_nettype wire

/* File: src/objproto_host.sv */
// Host end: runs the safe configuration download, saves to NV, waits
// for the completion message, then pulses the device reset.
// Assumes a start pulse and the target settings from user logic.
`timescale 1ns/100ps
`default_nettype none
module objproto_host
  import objproto_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  objproto_if.host        link,
  input  wire logic       start,
  input  wire logic [7:0] idle_int,
  input  wire logic [7:0] active_int,
  input  wire logic [7:0] test_interval,
  output logic            busy,
  output logic            done,
  output logic            error,
  output logic [7:0]      last_msg
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_WRITE = 3'b001,
    H_WAIT  = 3'b010,
    H_READ  = 3'b011,
    H_CHECK = 3'b100,
    H_RESET = 3'b101
  } host_state_t;

  typedef struct packed {
    host_state_t st;
    logic [3:0]  step;
    logic        wr, rd, rst_n, done, err;
    logic [3:0]  obj;
    logic [1:0]  fld;
    logic [7:0]  wdata;
    logic [7:0]  msg;
    logic [13:0] saves;
  } host_t;
  host_t s_q, s_d;

  // ********************************************************************
  // Download sequence
  // ********************************************************************
  always_comb begin
    s_d    = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    case (s_q.st)
      H_IDLE: begin
        s_d.rst_n = 1'b1;
        if (start && s_q.saves != 14'(SAVE_LIMIT)) begin
          s_d.st   = H_WRITE;
          s_d.step = 4'h0;
          s_d.done = 1'b0;
          s_d.err  = 1'b0;
        end
      end
      H_WRITE: begin
        s_d.wr   = 1'b1;
        s_d.step = s_q.step + 4'h1;
        case (s_q.step)
          4'h0: {s_d.obj, s_d.fld, s_d.wdata} =
                  {OBJ_POWER, FLD_ARG0, 8'h00};
          4'h1: {s_d.obj, s_d.fld, s_d.wdata} = {OBJ_POWER, FLD_ARG1, 8'h00};
          4'h2: {s_d.obj, s_d.fld, s_d.wdata} =
                  {OBJ_TEST, FLD_CTRL, 8'h01};
          4'h3: {s_d.obj, s_d.fld, s_d.wdata} = {OBJ_TEST, FLD_ARG0, 8'h07};
          4'h4: {s_d.obj, s_d.fld, s_d.wdata} =
                  {OBJ_TEST, FLD_ARG1, test_interval};
          4'h5: {s_d.obj, s_d.fld, s_d.wdata} =
                  {OBJ_TEST, FLD_CTRL, 8'h03};
          4'h6: {s_d.obj, s_d.fld, s_d.wdata} =
                  {OBJ_TOUCH, FLD_CTRL, 8'h01};
          4'h7: {s_d.obj, s_d.fld, s_d.wdata} = {OBJ_POWER, FLD_ARG0, idle_int};
          4'h8: {s_d.obj, s_d.fld, s_d.wdata} =
                  {OBJ_POWER, FLD_ARG1, active_int};
          default: begin
            {s_d.obj, s_d.fld, s_d.wdata} =
              {OBJ_CMD, FLD_ARG0, CMD_SAVE_NV};
            s_d.saves = s_q.saves + 14'h0001;
            s_d.st    = H_WAIT;
          end
        endcase
      end
      H_WAIT: begin
        // Same-clock level from the device, read directly: a delayed copy
        // would still show a message after the queue read and cause a poll
        if (!link.message_pending_n) begin
          s_d.rd  = 1'b1;
          s_d.obj = OBJ_MSG;
          s_d.st  = H_READ;
        end
      end
      H_READ: s_d.st = H_CHECK;   // Read strobe out this cycle; data valid in H_CHECK
      H_CHECK: begin
        s_d.msg = link.rdata;
        if (link.rdata == (RPT_NV_DONE | {4'h0, OBJ_CMD})) begin
          s_d.st    = H_RESET;
          s_d.rst_n = 1'b0;
        end else begin
          s_d.st = H_WAIT;   // Unexpected message: keep waiting
          s_d.err = link.rdata == RPT_TEST_BAD;
        end
      end
      H_RESET: begin
        s_d.rst_n = 1'b1;
        s_d.done  = 1'b1;
        s_d.st    = H_IDLE;
      end
      default: s_d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q       <= '0;
      s_q.rst_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.wr_stb      = s_q.wr;
  assign link.rd_stb      = s_q.rd;
  assign link.obj         = s_q.obj;
  assign link.fld         = s_q.fld;
  assign link.wdata       = s_q.wdata;
  assign link.dev_reset_n = s_q.rst_n;
  assign busy             = s_q.st != H_IDLE;
  assign done             = s_q.done;
  assign error            = s_q.err;
  assign last_msg         = s_q.msg;
endmodule : objproto_host
`default_nettype wire

/* File: src/objproto_if.sv */
// Interface: object link between the host end and the device end.
// Assumes both ends share mclk; the host drives reset_n of the device.
`timescale 1ns/100ps
`default_nettype none
interface objproto_if (
  input wire logic mclk
);
  logic       wr_stb;          // Host writes one object field
  logic       rd_stb;          // Host reads one object field
  logic [3:0] obj;
  logic [1:0] fld;
  logic [7:0] wdata;
  logic [7:0] rdata;           // Valid the cycle after rd_stb
  logic       message_pending_n;
  logic       dev_reset_n;     // Host-driven device reset pin

  modport device (input wr_stb, rd_stb, obj, fld, wdata, dev_reset_n,
                  output rdata, message_pending_n);
  modport host   (output wr_stb, rd_stb, obj, fld, wdata, dev_reset_n,
                  input rdata, message_pending_n);
endinterface : objproto_if
`default_nettype wire

/* File: src/objproto_pkg.sv */
// Package: object protocol constants shared by device and host ends.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
package objproto_pkg;

  // ********************************************************************
  // Object addresses on the link
  // ********************************************************************
  localparam logic [3:0] OBJ_MSG   = 4'h5;  // message_queue_object
  localparam logic [3:0] OBJ_CMD   = 4'h6;  // command_object
  localparam logic [3:0] OBJ_POWER = 4'h7;  // power_config_object
  localparam logic [3:0] OBJ_TEST  = 4'ha;  // self_test_control_object
  localparam logic [3:0] OBJ_GPIO  = 4'hb;  // gpio_config_object
  localparam logic [3:0] OBJ_DIAG  = 4'hc;  // diagnostic_readout_object
  localparam logic [3:0] OBJ_TOUCH = 4'hd;  // touchscreen_object

  // ********************************************************************
  // Field positions inside an object (field 0 is control)
  // ********************************************************************
  localparam logic [1:0] FLD_CTRL       = 2'h0;
  localparam logic [1:0] FLD_ARG0       = 2'h1;
  localparam logic [1:0] FLD_ARG1       = 2'h2;
  localparam int         CTRL_EN        = 0;   // Object enable bit
  localparam int         CTRL_REPORT_EN = 1;   // report_enable_bit
  localparam logic [7:0] FIELD_RST      = 8'h00;

  // ********************************************************************
  // Commands written into the command object
  // ********************************************************************
  localparam logic [7:0] CMD_NONE      = 8'h00;
  localparam logic [7:0] CMD_SAVE_NV   = 8'h01;
  localparam logic [7:0] CMD_DEBUG_ON  = 8'h02;
  localparam logic [7:0] CMD_DEBUG_OFF = 8'h03;
  localparam logic [7:0] CMD_SELFTEST  = 8'h04;

  // ********************************************************************
  // Message report identifiers (RPT_NV_DONE low nibble = source object)
  // ********************************************************************
  localparam logic [7:0] RPT_NONE     = 8'hff;
  localparam logic [7:0] RPT_NV_DONE  = 8'h10;  // OR'd with object id
  localparam logic [7:0] RPT_TEST_OK  = 8'h20;
  localparam logic [7:0] RPT_TEST_BAD = 8'h30;

  // ********************************************************************
  // Timing and sizes
  // ********************************************************************
  localparam int         CLK_MHZ      = 20;
  localparam int         NV_WRITE_US  = 10;
  localparam int         NV_CYC       = NV_WRITE_US * CLK_MHZ;
  localparam int         MSGQ_DEPTH   = 4;
  localparam logic [7:0] PERIOD_TICK  = 8'h10;  // Cycles per interval unit
  localparam int         SAVE_LIMIT   = 10000;

endpackage : objproto_pkg

/* File: testbench/objproto_asserts.sv */
// Checker: timing relations on the object link between the two ends.
// Assumes the bench hands it the interface signals, mclk and sys_rst.
`timescale 1ns/100ps
`default_nettype none
module objproto_asserts
  import objproto_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [3:0] obj,
  input wire logic [1:0] fld,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       message_pending_n,
  input wire logic       dev_reset_n
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic      rpt_q;     // Report enable written into test object
  logic      id_ok_q;   // Completion id has been read back
  logic      rd_msg_q;  // Queue read in the last cycle
  wire logic rd_msg = rd_stb && (obj == OBJ_MSG);
  wire logic save   = wr_stb && (obj == OBJ_CMD) && (wdata == CMD_SAVE_NV);

  // Follows report enable and the returned completion id
  always_ff @(posedge mclk) begin
    if (sys_rst || !dev_reset_n) begin
      rpt_q    <= 1'b0;
      id_ok_q  <= 1'b0;
      rd_msg_q <= 1'b0;
    end else begin
      rd_msg_q <= rd_msg;
      if (wr_stb && obj == OBJ_TEST && fld == FLD_CTRL) begin
        rpt_q <= wdata[CTRL_REPORT_EN];
      end
      if (rd_msg_q && rdata == (RPT_NV_DONE | {4'h0, OBJ_CMD})) begin
        id_ok_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_ONE_STROBE: assert property (!(wr_stb && rd_stb))
    else $error("write and read strobes high together");
  AST_RST_PULSE: assert property (
    $fell(dev_reset_n) |=> dev_reset_n)
    else $error("device reset pulse longer than one cycle");
  AST_RST_AFTER_ID: assert property (
    $fell(dev_reset_n) |-> id_ok_q)
    else $error("device reset before completion id was read");
  AST_NV_DONE: assert property (save && rpt_q && dev_reset_n
    |-> ##[190:230] !message_pending_n)
    else $error("no pending message after non-volatile save");
  AST_PEND_HOLD: assert property ($rose(message_pending_n)
    |-> $past(rd_msg, 1) || $past(rd_msg, 2) || !$past(dev_reset_n))
    else $error("pending line released without a queue read");
  AST_EMPTY_RD: assert property (rd_msg && message_pending_n
    |=> rdata == RPT_NONE)
    else $error("empty queue read did not return the none id");
  AST_FULL_RD: assert property (rd_msg && !message_pending_n
    |=> rdata != RPT_NONE)
    else $error("pending line low but queue read returned none");
  AST_RST_IDLE: assert property (!dev_reset_n
    |=> message_pending_n [*2])
    else $error("message pending right after device reset");

  COV_SAVE: cover property (save ##[1:230] !message_pending_n);
  COV_RESET: cover property ($fell(dev_reset_n));
  COV_MSG_RD: cover property (rd_msg && !message_pending_n);
endmodule : objproto_asserts
`default_nettype wire

/* File: testbench/tb.sv */
// Testbench: host end drives a full download and save into device end.
// Assumes both ends share mclk; the done id comes from the package, settings from run_one.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import objproto_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       start = 1'b0;
  logic [7:0] idle_int = 8'h00;
  logic [7:0] active_int = 8'h00;
  logic [7:0] test_interval = 8'h00;
  logic [2:0] fault_in = 3'h0;
  logic [7:0] diag_data = 8'h00;
  logic       busy, done, error, debug_active, pins_alt_en, test_gpio;
  logic       touch_enabled;
  logic [7:0] last_msg, idle_q, active_q, snap_idle, snap_active;
  logic [7:0] first_pw;
  logic       snap_touch;
  int         bad_count = 0;
  int         compares = 0;
  int         seed = 32'hf24d4ea3;
  int         n_wr, pw_idx, oth_idx, save_idx, rpt_idx, n_pw;

  objproto_if link (.mclk(mclk));
  objproto_device objproto_device_i (.mclk(mclk), .sys_rst(sys_rst),
    .link(link), .fault_in(fault_in), .diag_data(diag_data),
    .debug_active(debug_active), .pins_alt_en(pins_alt_en),
    .test_gpio(test_gpio), .touch_enabled(touch_enabled),
    .idle_acquisition_interval(idle_q),
    .active_acquisition_interval(active_q));
  objproto_host objproto_host_i (.mclk(mclk), .sys_rst(sys_rst),
    .link(link), .start(start), .idle_int(idle_int),
    .active_int(active_int), .test_interval(test_interval),
    .busy(busy), .done(done), .error(error), .last_msg(last_msg));
  objproto_asserts objproto_asserts_i (.mclk(mclk), .sys_rst(sys_rst),
    .wr_stb(link.wr_stb), .rd_stb(link.rd_stb), .obj(link.obj),
    .fld(link.fld), .wdata(link.wdata), .rdata(link.rdata),
    .message_pending_n(link.message_pending_n),
    .dev_reset_n(link.dev_reset_n));

  // Clock and random device-side inputs
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    diag_data <= 8'($random(seed));
    fault_in  <= 3'($random(seed));
  end

  // Logs host writes and grabs settings just before the device reset
  always @(posedge mclk) begin
    if (link.wr_stb === 1'b1) begin
      n_wr = n_wr + 1;
      if (link.obj == OBJ_POWER) begin
        if (n_pw == 0) first_pw = link.wdata;
        n_pw = n_pw + 1;
        pw_idx = n_wr;
      end else if (link.obj == OBJ_CMD) begin
        if (link.wdata == CMD_SAVE_NV) save_idx = n_wr;
      end else begin
        oth_idx = n_wr;
      end
      if (link.obj == OBJ_TEST && link.fld == FLD_CTRL &&
          link.wdata[CTRL_REPORT_EN]) rpt_idx = n_wr;
    end
    if (link.dev_reset_n === 1'b0) begin
      snap_idle   = idle_q;
      snap_active = active_q;
      snap_touch  = touch_enabled;
    end
  end

  // ****************************************************************
  // Compare tasks and expectations
  // ****************************************************************
  function automatic logic [7:0] exp_done_id();
    return RPT_NV_DONE | {4'h0, OBJ_CMD};
  endfunction : exp_done_id

  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic check1(input string what, input logic exp, input logic got);
    check8(what, {7'h0, exp}, {7'h0, got});
  endtask : check1

  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // One download, save and reset cycle with the given targets
  task automatic run_one(input logic [7:0] i_v, input logic [7:0] a_v,
                         input logic [7:0] t_v);
    int n;
    n_wr = 0; n_pw = 0; pw_idx = 0; oth_idx = 0; save_idx = 0; rpt_idx = 0;
    first_pw = 8'h55;
    @(posedge mclk);
    idle_int      <= i_v;
    active_int    <= a_v;
    test_interval <= t_v;
    start         <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    @(posedge mclk);
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(posedge mclk);
    if (n == 3000) begin
      // Hang counts as a mismatch; the closing report still follows
      bad_count++;
      $display("CHECK FAILED done expected 1 seen %b", done);
      return;
    end
    #1;
    check1("error", 1'b0, error);
    check1("busy", 1'b0, busy);
    check8("last_msg", exp_done_id(), last_msg);
    check8("idle", i_v, snap_idle);
    check8("active", a_v, snap_active);
    check1("touch on", 1'b1, snap_touch);
    check8("first power write", 8'h00, first_pw);
    check1("power last", 1'b1, pw_idx > oth_idx);
    check1("save after config", 1'b1, save_idx > pw_idx);
    check1("rpt order", 1'b1, rpt_idx > 0 && rpt_idx < save_idx);
    check8("idle after reset", 8'h00, idle_q);
    check1("touch after reset", 1'b0, touch_enabled);
    check1("debug off", 1'b0, debug_active);
    check1("alt pins", 1'b1, pins_alt_en);
    check1("gpio idle", 1'b0, test_gpio);
  endtask : run_one

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    check1("pending idle", 1'b1, link.message_pending_n);
    check1("debug reset", 1'b0, debug_active);
    run_one(8'h00, 8'h00, 8'h00);
    run_one(8'hff, 8'hff, 8'h00);
    run_one(8'h01, 8'hfe, 8'h01);
    repeat (4) run_one(8'($random(seed)), 8'($random(seed)),
                       8'($random(seed)) & 8'h0f);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
